// ===== adcr_register_map.v
`timescale 1ns/1ps
`default_nettype none
`include "adcr_consts.vh"

// Summary of operation
// RQ1 - Sixteen volatile registers, lost on power loss
// RQ2 - Address auto-advances within one access
// RQ3 - Address zero: read-only result, 24/32 bits
// RQ4 - Modulator mode: result becomes 4-bit stream
// RQ5 - 8-bit key register locks serial writes
// RQ6 - 16-bit read-only configuration checksum
// RQ7 - 24-bit delay between scan cycles
// RQ8 - 24-bit offset correction value
// RQ9 - 24-bit gain correction value
// RQ10 - Input select applies only outside scan
// RQ11 - 24-bit scan sequence settings register
// RQ12 - Config byte d: mode, format, enables
// RQ13 - Interrupt byte: status, mode, enables
// RQ14 - Result refreshed on each data-ready event
// RQ15 - Result latched at read start, double-buffered
// RQ16 - Host writes reserved locations only defaults
module adcr_register_map #(
  parameter [7:0] UNLOCK_KEY = 8'h5a  // Arbitrary unlock value
) (
  input  wire        sys_clk_i,       // 200 MHz clock
  input  wire        sys_rst_i,       // Sync reset, active high
  input  wire        acc_start_i,     // Pulse: new access begins
  input  wire        acc_read_i,      // With start: access is a read
  input  wire [3:0]  acc_addr_i,      // With start: first address
  input  wire        acc_wr_i,        // Pulse: write word, advance
  input  wire [31:0] acc_wdata_i,     // Write data, low bits used
  input  wire        acc_rd_i,        // Pulse: read word, advance
  input  wire        conv_ready_i,    // Pulse: new conversion data
  input  wire [23:0] conv_data_i,     // Filtered conversion code
  input  wire [3:0]  mod_bits_i,      // Raw modulator outputs
  output reg  [31:0] acc_rdata_o,     // Read data
  output reg         acc_rvalid_o,    // Pulse: read data valid
  output reg  [7:0]  cfg_a_o,         // Config byte a
  output reg  [7:0]  cfg_b_o,         // Config byte b
  output reg  [7:0]  cfg_c_o,         // Config byte c
  output reg  [7:0]  cfg_d_o,         // Config byte d
  output reg  [7:0]  irq_ctrl_o,      // Interrupt byte
  output reg  [7:0]  mux_sel_o,       // Active input selection
  output reg  [23:0] seq_o,           // Scan settings
  output reg  [23:0] delay_o,         // Inter-cycle delay
  output reg  [23:0] offs_o,          // Offset correction
  output reg  [23:0] gain_o,          // Gain correction
  output reg         unlocked_o       // Writes currently allowed
);

  // Register storage, plain flops so nothing survives power loss
  reg [7:0]  config_byte_a;          // see RQ1
  reg [7:0]  config_byte_b;
  reg [7:0]  config_byte_c;
  reg [7:0]  config_byte_d;
  reg [3:0]  irq_ctrl;               // Writable low nibble
  reg        ready_flag;             // Sticky data-ready status
  reg [7:0]  input_select;
  reg [23:0] sequencer_settings;
  reg [23:0] inter_cycle_delay;
  reg [23:0] offset_correction;
  reg [23:0] gain_correction;
  reg [23:0] reserved_b;
  reg [7:0]  reserved_c;
  reg [7:0]  write_lock_key;
  reg [15:0] reserved_e;
  reg [15:0] config_checksum;
  reg [23:0] result_live;            // Refreshed on data ready
  reg [3:0]  mod_live;               // Latest modulator sample
  reg [31:0] result_hold;            // Frozen copy for a read
  reg [3:0]  addr;                   // Current access address
  reg [31:0] rd_word;                // Combinational read mux
  reg [31:0] result_fmt;             // Formatted live result
  wire       unlocked;               // Key matches
  wire       mod_mode;               // Modulator output mode
  wire       wr_en;                  // Write permitted this cycle
  wire       rd_start;               // Start of a read access

  assign unlocked = (write_lock_key == UNLOCK_KEY);
  assign mod_mode = irq_ctrl[`ADCR_MODE_BIT];                 // see RQ4
  // Lock register stays writable so a locked part can be opened
  assign wr_en    = acc_wr_i & (unlocked | (addr == `ADCR_A_LOCK)); // see RQ5
  assign rd_start = acc_start_i & acc_read_i;

  // Result formatting by output format and mode
  always @*
  begin
    if (mod_mode)
    begin
      result_fmt = {28'h0000000, mod_live};                   // see RQ4
    end
    else if (config_byte_d[`ADCR_FMT_HI:`ADCR_FMT_LO] == 2'h0)
    begin
      result_fmt = {8'h00, result_live};                      // see RQ3
    end
    else
    begin
      // 32-bit formats carry the sign in the top byte
      result_fmt = {{8{result_live[23]}}, result_live};       // see RQ3
    end
  end

  // Read multiplexer; reserved locations read their stored value
  always @*
  begin
    case (addr)
      `ADCR_A_RESULT: rd_word = result_hold;                  // see RQ15
      `ADCR_A_CFG_A:  rd_word = {24'h000000, config_byte_a};
      `ADCR_A_CFG_B:  rd_word = {24'h000000, config_byte_b};
      `ADCR_A_CFG_C:  rd_word = {24'h000000, config_byte_c};
      `ADCR_A_CFG_D:  rd_word = {24'h000000, config_byte_d};
      `ADCR_A_IRQ:    rd_word = {25'h0, ready_flag, 2'h0, irq_ctrl};
      `ADCR_A_INSEL:  rd_word = {24'h000000, input_select};
      `ADCR_A_SEQ:    rd_word = {8'h00, sequencer_settings};
      `ADCR_A_DELAY:  rd_word = {8'h00, inter_cycle_delay};
      `ADCR_A_OFFS:   rd_word = {8'h00, offset_correction};
      `ADCR_A_GAIN:   rd_word = {8'h00, gain_correction};
      `ADCR_A_RSV_B:  rd_word = {8'h00, reserved_b};
      `ADCR_A_RSV_C:  rd_word = {24'h000000, reserved_c};
      `ADCR_A_LOCK:   rd_word = {24'h000000, write_lock_key};
      `ADCR_A_RSV_E:  rd_word = {16'h0000, reserved_e};
      default:        rd_word = {16'h0000, config_checksum};  // see RQ6
    endcase
  end

  // Address pointer: loaded at start, advances on every word
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      addr <= 4'h0;
    end
    else if (acc_start_i)
    begin
      addr <= acc_addr_i;
    end
    else if (acc_wr_i | acc_rd_i)
    begin
      addr <= addr + 4'h1;  // Wraps 0xf to 0x0, see RQ2
    end
  end

  // Live result and read snapshot
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      result_live <= `ADCR_RST_B24;
      mod_live    <= 4'h0;
      result_hold <= 32'h00000000;
    end
    else
    begin
      if (conv_ready_i)
      begin
        result_live <= conv_data_i;                           // see RQ14
      end
      mod_live <= mod_bits_i;                                 // see RQ4
      // Snapshot keeps a slow read intact while new data lands
      if (rd_start)
      begin
        result_hold <= result_fmt;                            // see RQ15
      end
    end
  end

  // Data-ready flag: set wins over the clear made by a read start
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      ready_flag <= 1'b0;
    end
    else if (conv_ready_i)
    begin
      ready_flag <= 1'b1;                                     // see RQ13
    end
    else if (rd_start && acc_addr_i == `ADCR_A_RESULT)
    begin
      ready_flag <= 1'b0;
    end
  end

  // Register writes; address zero and the checksum ignore writes
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      config_byte_a      <= `ADCR_RST_CFG_A;
      config_byte_b      <= `ADCR_RST_CFG_B;
      config_byte_c      <= `ADCR_RST_B8;
      config_byte_d      <= `ADCR_RST_B8;
      irq_ctrl           <= `ADCR_RST_IRQ;
      input_select       <= `ADCR_RST_B8;
      sequencer_settings <= `ADCR_RST_B24;
      inter_cycle_delay  <= `ADCR_RST_B24;
      offset_correction  <= `ADCR_RST_B24;
      gain_correction    <= `ADCR_RST_B24;
      reserved_b         <= `ADCR_RST_B24;
      reserved_c         <= `ADCR_RST_B8;
      write_lock_key     <= `ADCR_RST_B8;
      reserved_e         <= `ADCR_RST_B16;
    end
    else if (wr_en)
    begin
      case (addr)
        `ADCR_A_CFG_A: config_byte_a <= acc_wdata_i[7:0];
        `ADCR_A_CFG_B: config_byte_b <= acc_wdata_i[7:0];
        `ADCR_A_CFG_C: config_byte_c <= acc_wdata_i[7:0];
        `ADCR_A_CFG_D: config_byte_d <= acc_wdata_i[7:0];     // see RQ12
        `ADCR_A_IRQ:   irq_ctrl <= acc_wdata_i[3:0];          // see RQ13
        `ADCR_A_INSEL: input_select <= acc_wdata_i[7:0];
        `ADCR_A_SEQ:   sequencer_settings <= acc_wdata_i[23:0]; // see RQ11
        `ADCR_A_DELAY: inter_cycle_delay <= acc_wdata_i[23:0];  // see RQ7
        `ADCR_A_OFFS:  offset_correction <= acc_wdata_i[23:0];  // see RQ8
        `ADCR_A_GAIN:  gain_correction <= acc_wdata_i[23:0];    // see RQ9
        // Reserved cells simply store what the host puts there
        `ADCR_A_RSV_B: reserved_b <= acc_wdata_i[23:0];       // see RQ16
        `ADCR_A_RSV_C: reserved_c <= acc_wdata_i[7:0];
        `ADCR_A_LOCK:  write_lock_key <= acc_wdata_i[7:0];    // see RQ5
        `ADCR_A_RSV_E: reserved_e <= acc_wdata_i[15:0];
        default:       reserved_c <= reserved_c;  // Read-only cells
      endcase
    end
  end

  // Checksum: sum of bytes, irq nibble and 16-bit low halves plus top bytes of wide words, one cycle late
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      config_checksum <= `ADCR_RST_B16;
    end
    else
    begin
      config_checksum <= {8'h00, config_byte_a} + {8'h00, config_byte_b}
        + {8'h00, config_byte_c} + {8'h00, config_byte_d}
        + {12'h000, irq_ctrl} + {8'h00, input_select}
        + sequencer_settings[15:0] + {8'h00, sequencer_settings[23:16]}
        + inter_cycle_delay[15:0] + {8'h00, inter_cycle_delay[23:16]}
        + offset_correction[15:0] + {8'h00, offset_correction[23:16]}
        + gain_correction[15:0] + {8'h00, gain_correction[23:16]};
    end                                                       // see RQ6
  end

  // Output flops
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      acc_rdata_o  <= 32'h00000000;
      acc_rvalid_o <= 1'b0;
      cfg_a_o      <= `ADCR_RST_CFG_A;
      cfg_b_o      <= `ADCR_RST_CFG_B;
      cfg_c_o      <= `ADCR_RST_B8;
      cfg_d_o      <= `ADCR_RST_B8;
      irq_ctrl_o   <= `ADCR_RST_B8;
      mux_sel_o    <= `ADCR_RST_B8;
      seq_o        <= `ADCR_RST_B24;
      delay_o      <= `ADCR_RST_B24;
      offs_o       <= `ADCR_RST_B24;
      gain_o       <= `ADCR_RST_B24;
      unlocked_o   <= 1'b0;
    end
    else
    begin
      acc_rvalid_o <= acc_rd_i;
      if (acc_rd_i)
      begin
        acc_rdata_o <= rd_word;
      end
      cfg_a_o    <= config_byte_a;
      cfg_b_o    <= config_byte_b;
      cfg_c_o    <= config_byte_c;
      cfg_d_o    <= config_byte_d;
      irq_ctrl_o <= {1'b0, ready_flag, 2'h0, irq_ctrl};
      // Scan active when any channel bit set: selection frozen then
      if (sequencer_settings[15:0] == 16'h0000)
      begin
        mux_sel_o <= input_select;                            // see RQ10
      end
      seq_o      <= sequencer_settings;
      delay_o    <= inter_cycle_delay;
      offs_o     <= offset_correction;
      gain_o     <= gain_correction;
      unlocked_o <= unlocked;
    end
  end

endmodule
`default_nettype wire

// ===== adcr_consts.vh
`ifndef ADCR_CONSTS_VH
`define ADCR_CONSTS_VH

// Register addresses
`define ADCR_A_RESULT   4'h0
`define ADCR_A_CFG_A    4'h1
`define ADCR_A_CFG_B    4'h2
`define ADCR_A_CFG_C    4'h3
`define ADCR_A_CFG_D    4'h4
`define ADCR_A_IRQ      4'h5
`define ADCR_A_INSEL    4'h6
`define ADCR_A_SEQ      4'h7
`define ADCR_A_DELAY    4'h8
`define ADCR_A_OFFS     4'h9
`define ADCR_A_GAIN     4'ha
`define ADCR_A_RSV_B    4'hb
`define ADCR_A_RSV_C    4'hc
`define ADCR_A_LOCK     4'hd
`define ADCR_A_RSV_E    4'he
`define ADCR_A_CKSUM    4'hf

// Reset values
`define ADCR_RST_CFG_A  8'hc0
`define ADCR_RST_CFG_B  8'h0c
`define ADCR_RST_B8     8'h00
`define ADCR_RST_B16    16'h0000
`define ADCR_RST_B24    24'h000000
`define ADCR_RST_IRQ    4'h0

// Field positions
`define ADCR_FMT_HI     5
`define ADCR_FMT_LO     4
`define ADCR_MODE_BIT   3
`define ADCR_RDY_BIT    6

`endif

// ===== adcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host side of the access port, driven off the falling edge
module adcr_host_model (
  input  wire logic        clk_i,   // Device clock
  input  wire logic [31:0] rdata_i, // Read data from device
  output var  logic        start_o, // Access start pulse
  output var  logic        read_o,  // Access is a read
  output var  logic [3:0]  addr_o,  // First address
  output var  logic        wr_o,    // Write word pulse
  output var  logic [31:0] wdata_o, // Write data
  output var  logic        rd_o     // Read word pulse
);
  initial {start_o, read_o, addr_o, wr_o, wdata_o, rd_o} = '0;
  // Every pulse is followed by a gap cycle, so no line is set twice at once
  task automatic open_acc(input logic r, input logic [3:0] a);
    @(negedge clk_i);
    start_o = 1'b1;
    read_o  = r;
    addr_o  = a;
    @(negedge clk_i);
    start_o = 1'b0;
    // Stale qualifiers are inverted so nothing relies on them
    read_o  = ~r;
    addr_o  = ~a;
  endtask
  // One word written, address advances inside the device
  task automatic put(input logic [31:0] d);
    @(negedge clk_i);
    wr_o    = 1'b1;
    wdata_o = d;
    @(negedge clk_i);
    wr_o    = 1'b0;
    wdata_o = ~d;
  endtask
  // One word read; data is registered, taken a cycle later
  task automatic get(output logic [31:0] d);
    @(negedge clk_i);
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    d    = rdata_i;
  endtask
endmodule
`default_nettype wire

// ===== adcr_map_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the register map
module adcr_map_sva (
  input wire logic        sys_clk_i,    // Clock
  input wire logic        sys_rst_i,    // Sync reset
  input wire logic        acc_rd_i,     // Read pulse
  input wire logic        acc_wr_i,     // Write pulse
  input wire logic        conv_ready_i, // Data-ready pulse
  input wire logic [31:0] acc_rdata_o,  // Read data
  input wire logic        acc_rvalid_o, // Read valid
  input wire logic [7:0]  cfg_a_o,      // Config a
  input wire logic [7:0]  cfg_b_o,      // Config b
  input wire logic [7:0]  cfg_d_o,      // Config d
  input wire logic [7:0]  irq_ctrl_o,   // Interrupt byte
  input wire logic [7:0]  mux_sel_o,    // Input selection
  input wire logic [23:0] seq_o,        // Scan settings
  input wire logic        unlocked_o    // Write enable
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_rv_on; acc_rd_i |=> acc_rvalid_o; endproperty
  a_rv_on: assert property (p_rv_on) else $error("rvalid late");
  property p_rv_off; !acc_rd_i |=> !acc_rvalid_o; endproperty
  a_rv_off: assert property (p_rv_off) else $error("rvalid stray");
  property p_hold; !acc_rd_i |=> $stable(acc_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_rst;
    $fell(sys_rst_i) |-> cfg_a_o == 8'hc0 && cfg_b_o == 8'h0c && !unlocked_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  property p_irq0; irq_ctrl_o[7] == 1'b0 && irq_ctrl_o[5:4] == 2'h0;
  endproperty
  a_irq0: assert property (p_irq0) else $error("irq spare bit");
  property p_unl;
    $rose(unlocked_o) |-> $past(acc_wr_i, 2) || $past(acc_wr_i, 3);
  endproperty
  a_unl: assert property (p_unl) else $error("unlock no write");
  property p_cfgd; $changed(cfg_d_o) |-> $past(acc_wr_i, 2); endproperty
  a_cfgd: assert property (p_cfgd) else $error("cfg d no write");
  property p_rdy;
    $rose(irq_ctrl_o[6]) |-> $past(conv_ready_i, 2) || $past(conv_ready_i);
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready no event");
  // The scan copy and the selection share one flop delay, so look at
  // the scan copy in the same sample that shows the new selection
  property p_mux;
    $changed(mux_sel_o) |-> seq_o[15:0] == 16'h0000;
  endproperty
  a_mux: assert property (p_mux) else $error("mux in scan");
endmodule
bind adcr_register_map adcr_map_sva i_sva (.sys_clk_i, .sys_rst_i,
  .acc_rd_i, .acc_wr_i, .conv_ready_i, .acc_rdata_o, .acc_rvalid_o,
  .cfg_a_o, .cfg_b_o, .cfg_d_o, .irq_ctrl_o, .mux_sel_o, .seq_o,
  .unlocked_o);
`default_nettype wire

// ===== adcr_register_map_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Bench: integer model of the map, compared at every read and output
module adcr_register_map_tb;
  logic sys_clk_i = 0, sys_rst_i = 1, acc_start_i, acc_read_i, acc_wr_i;
  logic acc_rd_i, conv_ready_i = 0, acc_rvalid_o, unlocked_o;
  logic [3:0] acc_addr_i, mod_bits_i = 0;
  logic [31:0] acc_wdata_i, acc_rdata_o, m[16], snap, d;
  logic [23:0] conv_data_i = 0, seq_o, delay_o, offs_o, gain_o, res = 0;
  logic [7:0] cfg_a_o, cfg_b_o, cfg_c_o, cfg_d_o, irq_ctrl_o, mux_sel_o;
  logic rdy = 0;
  int a_ptr, bad_count = 0, cmp_count = 0;
  adcr_register_map i_dut (.sys_clk_i, .sys_rst_i, .acc_start_i,
    .acc_read_i, .acc_addr_i, .acc_wr_i, .acc_wdata_i, .acc_rd_i,
    .conv_ready_i, .conv_data_i, .mod_bits_i, .acc_rdata_o, .acc_rvalid_o,
    .cfg_a_o, .cfg_b_o, .cfg_c_o, .cfg_d_o, .irq_ctrl_o, .mux_sel_o,
    .seq_o, .delay_o, .offs_o, .gain_o, .unlocked_o);
  adcr_host_model i_host (.clk_i(sys_clk_i), .rdata_i(acc_rdata_o),
    .start_o(acc_start_i), .read_o(acc_read_i), .addr_o(acc_addr_i),
    .wr_o(acc_wr_i), .wdata_o(acc_wdata_i), .rd_o(acc_rd_i));
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    cmp_count++;
    if (act !== exp)
    begin
      bad_count++;
      $display("mismatch t=%0t got %h want %h", $time, act, exp);
    end
  endtask
  // Writable width of each place; only the low nibble of the irq byte
  function automatic logic [31:0] wmask(int a);
    if (a == 5) return 32'hf;
    if (a >= 7 && a <= 11) return 32'hffffff;
    return (a == 14) ? 32'hffff : 32'hff;
  endfunction
  // Configuration sum: bytes, irq nibble, and halves of the wide words
  function automatic logic [31:0] cks();
    logic [15:0] s;
    s = 16'h0000;
    for (int j = 1; j <= 10; j++) s += m[j][15:0] + m[j][23:16];
    return {16'h0, s};
  endfunction
  function automatic logic [31:0] live();
    if (m[5][3]) return {28'h0, mod_bits_i};
    if (m[4][5:4] == 2'h0) return {8'h0, res};
    return {{8{res[23]}}, res};
  endfunction
  task automatic go(input logic r, input int a);
    i_host.open_acc(r, a[3:0]);
    a_ptr = a;
    // Snapshot on every read start; address zero clears ready
    if (r) snap = live();
    if (r && a == 0) rdy = 0;
  endtask
  task automatic wr_word(input logic [31:0] w);
    i_host.put(w);
    if ((m[13] == 32'h5a || a_ptr == 13) && a_ptr % 15 != 0)
      m[a_ptr] = w & wmask(a_ptr);
    a_ptr = (a_ptr + 1) % 16;
  endtask
  task automatic rd_word();
    i_host.get(d);
    chk({31'h0, acc_rvalid_o}, 32'h1);
    if (a_ptr == 0) chk(d, snap);
    else if (a_ptr == 5) chk(d, {25'h0, rdy, 2'h0, m[5][3:0]});
    else if (a_ptr == 15) chk(d, cks());
    else chk(d, m[a_ptr]);
    a_ptr = (a_ptr + 1) % 16;
  endtask
  task automatic convert(input logic [23:0] c);
    @(negedge sys_clk_i);
    conv_ready_i = 1;
    conv_data_i = c;
    @(negedge sys_clk_i);
    conv_ready_i = 0;
    conv_data_i = ~c;
    res = c;
    rdy = 1;
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #100000;
    bad_count++;
    test_done();
  end
  initial
  begin
    void'($urandom(32'h67d00f7f));
    foreach (m[i]) m[i] = 0;
    m[1] = 32'hc0;
    m[2] = 32'h0c;
    repeat (4) @(negedge sys_clk_i);
    sys_rst_i = 0;
    chk({cfg_b_o, cfg_a_o}, 32'h0cc0);
    chk({31'h0, unlocked_o}, 32'h0);
    // Locked: a config write must be dropped
    go(0, 4);
    wr_word($urandom());
    go(1, 4);
    rd_word();
    go(0, 13);
    wr_word(32'h5a);
    repeat (2) @(negedge sys_clk_i);
    chk({31'h0, unlocked_o}, 32'h1);
    // Burst through all places with wrap; reserved get defaults only
    go(0, 1);
    for (int i = 1; i <= 16; i++)
      wr_word(i == 13 ? 32'h5a : i inside {11, 12, 14} ? 0 : $urandom());
    repeat (2) @(negedge sys_clk_i);
    chk({8'h0, seq_o}, m[7]);
    chk({8'h0, delay_o}, m[8]);
    chk({8'h0, offs_o}, m[9]);
    chk({8'h0, gain_o}, m[10]);
    chk({cfg_d_o, cfg_c_o}, {m[4][7:0], m[3][7:0]});
    chk({8'h0, irq_ctrl_o, cfg_b_o, cfg_a_o}, {9'h0, rdy, 2'h0, m[5][3:0], m[2][7:0], m[1][7:0]});
    go(1, 1);
    repeat (15) rd_word();
    // Selection follows only outside scan
    for (int k = 0; k < 2; k++)
    begin
      go(0, 7);
      wr_word(k);
      go(0, 6);
      // In scan the new selection differs but must not reach the output
      wr_word(k ? ~snap : $urandom());
      if (k == 0) snap = m[6];
      repeat (2) @(negedge sys_clk_i);
      chk({24'h0, mux_sel_o}, snap);
    end
    // Every format and modulator mode; a new result after read start
    for (int k = 0; k < 5; k++)
    begin
      go(0, 4);
      wr_word(($urandom() & 32'hcf) | (k[1:0] << 4));
      wr_word(k == 4 ? 32'h8 : 32'h0);
      mod_bits_i = 4'($urandom());
      convert(24'($urandom()));
      go(1, 0);
      convert(24'($urandom()));
      rd_word();
      chk({24'h0, irq_ctrl_o}, {25'h0, rdy, 2'h0, m[5][3:0]});
    end
    // A read start at address zero clears the ready status
    go(1, 0);
    repeat (2) @(negedge sys_clk_i);
    chk({24'h0, irq_ctrl_o}, {25'h0, rdy, 2'h0, m[5][3:0]});
    test_done();
  end
endmodule
`default_nettype wire
